/* File: rtl/lcdhp_pkg.sv */
// Shared constants and types for the LCD host port block
package lcdhp_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_CHIP_ADDR = 8'h04;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
    localparam logic [APB_AW-1:0] OFS_LAST_CMD = 8'h0C;

    // CTRL and STATUS fields
    localparam int CTRL_ADDR_CHK_BIT = 0;
    localparam int ST_PAR_BIT = 0;
    localparam int ST_MODE_LSB = 1;
    localparam int ST_CHAR_RIGHT_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_DIR_OUT_BIT = 6;

    localparam logic CTRL_RST = 1'b0;
    localparam logic [1:0] CHIP_ADDR_RST = 2'h0;
    localparam logic [7:0] CMD_RST = 8'h00;

    // ----------------------------------------------------------------
    // Mode setting commands
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SET_WRITE = 8'h64;
    localparam logic [7:0] CMD_SET_READ = 8'h60;
    localparam logic [7:0] CMD_SET_AND = 8'h6C;
    localparam logic [7:0] CMD_SET_OR = 8'h68;
    localparam logic [7:0] CMD_CHAR_LEFT = 8'h71;
    localparam logic [7:0] CMD_CHAR_RIGHT = 8'h72;

    // ----------------------------------------------------------------
    // Link and character constants
    // ----------------------------------------------------------------
    localparam int SYNC_W = 10;
    localparam logic [2:0] SER_LAST = 3'h7;
    localparam logic [2:0] PAR_LAST = 3'h1;
    localparam logic [2:0] CHAR_LAST_COL = 3'h4;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam int GLYPH_N = 160;
    localparam int GLYPH_W = 35;
    localparam int COL_W = 7;
    localparam logic [7:0] ASCII_LO = 8'h20;
    localparam logic [7:0] ASCII_HI = 8'h7F;
    localparam logic [7:0] KANA_LO = 8'hA0;
    localparam logic [7:0] KANA_HI = 8'hDF;
    localparam logic [7:0] KANA_BASE = 8'h60;

    typedef enum logic [2:0] {
        DM_WRITE = 3'b000,
        DM_READ = 3'b001,
        DM_AND = 3'b010,
        DM_OR = 3'b011,
        DM_CHAR = 3'b100
    } lcdhp_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FIN = 3'b001,
        ST_RMW_RD = 3'b010,
        ST_RMW_WR = 3'b011,
        ST_CHAR_WR = 3'b100,
        ST_FETCH = 3'b101,
        ST_FETCH_LD = 3'b110
    } lcdhp_state_t;

endpackage

/* File: rtl/lcdhp_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module lcdhp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule // lcdhp_sync

/* File: rtl/lcdhp_chargen.sv */
// Character code to 5x7 column pattern lookup
`timescale 1ns/1ps
module lcdhp_chargen
    import lcdhp_pkg::*;
#(
    // Mask pattern table, glyph i at bits [35*i +: 35], column c at [7*c +: 7]
    parameter logic [GLYPH_N*GLYPH_W-1:0] GLYPH_ROM = '0
) (
    // Lookup
    input wire logic [7:0] code,
    input wire logic [2:0] col,
    output logic [COL_W-1:0] pattern
);
    logic [7:0] idx;
    logic hit;
    logic [GLYPH_W-1:0] glyph;

    always_comb begin
        idx = 8'h00;
        hit = 1'b0;
        if (code >= ASCII_LO && code <= ASCII_HI) begin
            idx = code - ASCII_LO;
            hit = 1'b1;
        end else if (code >= KANA_LO && code <= KANA_HI) begin
            idx = code - KANA_LO + KANA_BASE;
            hit = 1'b1;
        end
        glyph = GLYPH_ROM[GLYPH_W*idx +: GLYPH_W];
        // Codes outside both ranges give a blank cell
        pattern = hit ? glyph[COL_W*col +: COL_W] : '0;
    end
endmodule // lcdhp_chargen

/* File: rtl/lcdhp_port.sv */
// LCD controller host port: serial/nibble link, mode handling and APB status
//
// Contract
// - Interface select high at reset release picks nibble link, low picks serial.
// - Reset puts data processing mode to write so commands are accepted.
// - Write, AND, OR, character modes capture bits or nibbles on rising edges.
// - Read mode drives bits or nibbles on falling strobe or serial clock edges.
// - One 8-bit holding register sits between link and display memory.
// - Command/data select high routes the finished byte to the command decoder.
// - Write mode stores a data byte unchanged at the current pointer.
// - AND or OR mode merges data with the memory byte and writes back.
// - Character mode writes five 7-bit pattern columns to consecutive addresses.
// - Output only in read mode; entering read mode prefetches one byte.
// - Serial read shifts the holding register out MSB first on falling clocks.
// - Nibble read gives upper nibble on first falling strobe, lower on second.
// - After each eight bits delivered, the next memory byte is fetched.
// - Character generator works only after a character mode command.
// - Codes 20H to 7FH map to Latin and symbol patterns.
// - Codes A0H to DFH map to katakana and symbol patterns.
// - Byte latched at second strobe rise or eighth serial clock rise.
// - Busy output low from byte latch until processing completes.
// - Serial input shifts in on rising clock, first bit is the MSB.
// - Deselected or address mismatch ignores strobes, floats nibble bus and busy.
`timescale 1ns/1ps
module lcdhp_port
    import lcdhp_pkg::*;
#(
    parameter logic [GLYPH_N*GLYPH_W-1:0] GLYPH_ROM = '0
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Host link pins
    input wire logic CS_N,
    input wire logic NIBBLE_STROBE_N,
    input wire logic CMD_DATA_SEL,
    input wire logic IF_SELECT,
    input wire logic [1:0] CHIP_ID_PINS,
    input wire logic [3:0] NIBBLE_BUS_I,
    output logic [3:0] NIBBLE_BUS_O,
    output logic [3:0] NIBBLE_BUS_OE,
    output logic BUSY_N_O,
    output logic BUSY_N_OE,
    // Command decoder output
    output logic CMD_VALID,
    output logic [7:0] CMD_BYTE,
    // Display memory side
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [2:0] MEM_COL,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import lcdhp_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] pin_raw, pin_s;
    logic s_stb_n, s_cs_n, s_cd, s_ifsel;
    logic [1:0] s_id;
    logic [3:0] s_nib;

    assign pin_raw = {NIBBLE_BUS_I, CHIP_ID_PINS, IF_SELECT, CMD_DATA_SEL, CS_N,
                      NIBBLE_STROBE_N};

    lcdhp_sync #(.W(SYNC_W)) u_sync (.clk(REF_CLK), .rst_b(RST_B), .d(pin_raw), .q(pin_s));

    assign {s_nib, s_id, s_ifsel, s_cd, s_cs_n, s_stb_n} = pin_s;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0] strap_cnt_ff, chip_addr_ff;
    logic par_mode_ff, addr_chk_ff, char_right_ff, stb_prev_ff, cmd_valid_ff;
    logic mem_rd_ff, mem_wr_ff, pslverr_ff;
    lcdhp_mode_t mode_ff;
    lcdhp_state_t state_ff;
    logic [7:0] sr_ff, cmd_byte_ff, mem_wdata_ff, nxt_sr;
    logic [2:0] cnt_ff, col_ff, mem_col_ff;
    logic [3:0] out_nib_ff;
    logic [31:0] prdata_ff;
    logic [COL_W-1:0] glyph_col;
    logic addr_ok, sel, busy, dir_in, rise, fall, last_unit;
    logic byte_done, latch_ev, deliver_ev, fetch_load;

    // ----------------------------------------------------------------
    // Interface strap capture
    // ----------------------------------------------------------------
    // Synchroniser output is only trustworthy a few edges after release
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_cnt_ff <= 2'h0;
            par_mode_ff <= 1'b0;
        end else if (strap_cnt_ff != STRAP_WAIT) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            par_mode_ff <= s_ifsel;
        end
    end

    // ----------------------------------------------------------------
    // Selection and edge detection
    // ----------------------------------------------------------------
    // Nibble link always compares chip id; serial only when enabled
    assign addr_ok = !(par_mode_ff || addr_chk_ff) || (s_id == chip_addr_ff);
    assign sel = !s_cs_n && addr_ok && (strap_cnt_ff == STRAP_WAIT);
    assign busy = (state_ff != ST_IDLE);
    // A command byte is always input, even in read mode
    assign dir_in = (mode_ff != DM_READ) || s_cd;
    assign rise = sel && !busy && s_stb_n && !stb_prev_ff;
    assign fall = sel && !busy && !s_stb_n && stb_prev_ff;
    assign last_unit = par_mode_ff ? (cnt_ff == PAR_LAST) : (cnt_ff == SER_LAST);
    assign byte_done = rise && last_unit;
    assign latch_ev = byte_done && dir_in;
    assign deliver_ev = byte_done && !dir_in;
    assign fetch_load = (state_ff == ST_FETCH_LD);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stb_prev_ff <= 1'b1;
        end else begin
            stb_prev_ff <= s_stb_n;
        end
    end

    // ----------------------------------------------------------------
    // Holding register and link counter
    // ----------------------------------------------------------------
    always_comb begin
        if (par_mode_ff) begin
            nxt_sr = {sr_ff[3:0], s_nib};
        end else begin
            nxt_sr = {sr_ff[6:0], s_nib[0]};
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sr_ff <= 8'h00;
            cnt_ff <= 3'h0;
        end else if (fetch_load) begin
            sr_ff <= MEM_RDATA;
        end else if (!sel) begin
            // Deselect abandons a half transferred byte
            cnt_ff <= 3'h0;
        end else if (rise) begin
            cnt_ff <= last_unit ? 3'h0 : cnt_ff + 3'h1;
            if (dir_in) begin
                sr_ff <= nxt_sr;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            out_nib_ff <= 4'h0;
        end else if (fall && !dir_in) begin
            if (par_mode_ff) begin
                out_nib_ff <= (cnt_ff == 3'h0) ? sr_ff[7:4] : sr_ff[3:0];
            end else begin
                out_nib_ff <= {sr_ff[SER_LAST - cnt_ff], 3'h0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    always_comb begin
        NIBBLE_BUS_OE = 4'h0;
        if (sel && !dir_in) begin
            NIBBLE_BUS_OE = par_mode_ff ? 4'hF : 4'h8;
        end
    end

    assign NIBBLE_BUS_O = out_nib_ff;
    assign BUSY_N_O = !busy;
    assign BUSY_N_OE = sel;

    // ----------------------------------------------------------------
    // Command decode and data processing mode
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_ff <= DM_WRITE;
            char_right_ff <= 1'b0;
            cmd_byte_ff <= CMD_RST;
            cmd_valid_ff <= 1'b0;
        end else begin
            cmd_valid_ff <= latch_ev && s_cd;
            if (latch_ev && s_cd) begin
                cmd_byte_ff <= nxt_sr;
                unique case (nxt_sr)
                    CMD_SET_WRITE: mode_ff <= DM_WRITE;
                    CMD_SET_READ: mode_ff <= DM_READ;
                    CMD_SET_AND: mode_ff <= DM_AND;
                    CMD_SET_OR: mode_ff <= DM_OR;
                    CMD_CHAR_LEFT: begin
                        mode_ff <= DM_CHAR;
                        char_right_ff <= 1'b0;
                    end
                    CMD_CHAR_RIGHT: begin
                        mode_ff <= DM_CHAR;
                        char_right_ff <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign CMD_VALID = cmd_valid_ff;
    assign CMD_BYTE = cmd_byte_ff;

    // ----------------------------------------------------------------
    // Character generator
    // ----------------------------------------------------------------
    lcdhp_chargen #(.GLYPH_ROM(GLYPH_ROM)) u_chargen (
        .code(sr_ff),
        .col(col_ff),
        .pattern(glyph_col)
    );

    // ----------------------------------------------------------------
    // Processing sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= ST_IDLE;
            col_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    col_ff <= 3'h0;
                    if (latch_ev && s_cd) begin
                        // Entering read mode primes the holding register
                        state_ff <= (nxt_sr == CMD_SET_READ) ? ST_FETCH : ST_FIN;
                    end else if (latch_ev) begin
                        unique case (mode_ff)
                            DM_AND, DM_OR: state_ff <= ST_RMW_RD;
                            DM_CHAR: state_ff <= ST_CHAR_WR;
                            default: state_ff <= ST_FIN;
                        endcase
                    end else if (deliver_ev) begin
                        state_ff <= ST_FETCH;
                    end
                end
                ST_RMW_RD: state_ff <= ST_RMW_WR;
                ST_RMW_WR: state_ff <= ST_FIN;
                ST_CHAR_WR: begin
                    col_ff <= col_ff + 3'h1;
                    if (col_ff == CHAR_LAST_COL) begin
                        state_ff <= ST_FIN;
                    end
                end
                ST_FETCH: state_ff <= ST_FETCH_LD;
                ST_FETCH_LD: state_ff <= ST_FIN;
                ST_FIN: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Display memory strobes
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= 8'h00;
        end else begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            if (state_ff == ST_IDLE && latch_ev && !s_cd) begin
                if (mode_ff == DM_AND || mode_ff == DM_OR) begin
                    mem_rd_ff <= 1'b1;
                end else if (mode_ff == DM_WRITE) begin
                    mem_wr_ff <= 1'b1;
                    mem_wdata_ff <= nxt_sr;
                end
            end else if (state_ff == ST_IDLE && (deliver_ev || (latch_ev && s_cd
                         && nxt_sr == CMD_SET_READ))) begin
                mem_rd_ff <= 1'b1;
            end else if (state_ff == ST_RMW_WR) begin
                mem_wr_ff <= 1'b1;
                mem_wdata_ff <= (mode_ff == DM_AND) ? (sr_ff & MEM_RDATA)
                                                    : (sr_ff | MEM_RDATA);
            end else if (state_ff == ST_CHAR_WR) begin
                mem_wr_ff <= 1'b1;
                // Top bit is left for the cursor, never set by a glyph
                mem_wdata_ff <= {1'b0, glyph_col};
            end
        end
    end

    // Column offset of each write lags the sequencer by one edge
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mem_col_ff <= 3'h0;
        end else begin
            mem_col_ff <= (state_ff == ST_CHAR_WR) ? col_ff : 3'h0;
        end
    end

    assign MEM_RD = mem_rd_ff;
    assign MEM_WR = mem_wr_ff;
    assign MEM_WDATA = mem_wdata_ff;
    assign MEM_COL = mem_col_ff;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic apb_wr, apb_rd, apb_hit;

    assign apb_hit = (PADDR == OFS_CTRL) || (PADDR == OFS_CHIP_ADDR)
                     || (PADDR == OFS_STATUS) || (PADDR == OFS_LAST_CMD);
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr_chk_ff <= CTRL_RST;
            chip_addr_ff <= CHIP_ADDR_RST;
        end else if (apb_wr) begin
            if (PADDR == OFS_CTRL) begin
                addr_chk_ff <= PWDATA[CTRL_ADDR_CHK_BIT];
            end
            if (PADDR == OFS_CHIP_ADDR) begin
                chip_addr_ff <= PWDATA[1:0];
            end
        end
    end

    // Read data is captured in setup so the access phase answers at once
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            pslverr_ff <= !apb_hit;
            prdata_ff <= 32'h0000_0000;
            if (apb_rd) begin
                unique case (PADDR)
                    OFS_CTRL: prdata_ff[CTRL_ADDR_CHK_BIT] <= addr_chk_ff;
                    OFS_CHIP_ADDR: prdata_ff[1:0] <= chip_addr_ff;
                    OFS_STATUS: begin
                        prdata_ff[ST_PAR_BIT] <= par_mode_ff;
                        prdata_ff[ST_MODE_LSB +: 3] <= mode_ff;
                        prdata_ff[ST_CHAR_RIGHT_BIT] <= char_right_ff;
                        prdata_ff[ST_BUSY_BIT] <= busy;
                        prdata_ff[ST_DIR_OUT_BIT] <= !dir_in;
                    end
                    OFS_LAST_CMD: prdata_ff[7:0] <= cmd_byte_ff;
                    default: ;
                endcase
            end
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = prdata_ff;
    assign PSLVERR = pslverr_ff && PSEL && PENABLE;

endmodule // lcdhp_port

/* File: bench/lcdhp_port_checker.sv */
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module lcdhp_port_checker (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Link side
    input wire logic CS_N,
    input wire logic [3:0] NIBBLE_BUS_OE,
    input wire logic BUSY_N_O,
    input wire logic BUSY_N_OE,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_BYTE,
    // Memory side
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [2:0] MEM_COL,
    input wire logic [7:0] MEM_WDATA,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PSLVERR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // ----------------------------------------------------------------
    // Busy window
    // ----------------------------------------------------------------
    sequence s_busy_low;
        ##[0:2] !BUSY_N_O;
    endsequence
    sequence s_busy_done;
        ##[1:8] BUSY_N_O;
    endsequence
    property p_cmd_busy;
        CMD_VALID |-> s_busy_low;
    endproperty
    a_cmd_busy: assert property (p_cmd_busy) else $error("no busy after command");
    property p_busy_end;
        $fell(BUSY_N_O) |-> s_busy_done;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy too long");
    property p_cmd_pulse;
        $rose(CMD_VALID) |=> !CMD_VALID;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
    // ----------------------------------------------------------------
    // Direction and selection
    // ----------------------------------------------------------------
    property p_desel;
        CS_N [*3] |-> !BUSY_N_OE && NIBBLE_BUS_OE == 4'h0;
    endproperty
    a_desel: assert property (p_desel) else $error("pins driven while deselected");
    property p_oe_codes;
        NIBBLE_BUS_OE == 4'h0 || NIBBLE_BUS_OE == 4'hF || NIBBLE_BUS_OE == 4'h8;
    endproperty
    a_oe_codes: assert property (p_oe_codes) else $error("odd output enable");
    property p_rd_out;
        CMD_VALID && CMD_BYTE == lcdhp_pkg::CMD_SET_READ |-> MEM_RD;
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("no prefetch on read entry");
    property p_wr_in;
        MEM_WR |-> NIBBLE_BUS_OE == 4'h0;
    endproperty
    a_wr_in: assert property (p_wr_in) else $error("write while driving");
    property p_char_col;
        MEM_WR && MEM_COL != 3'h0 |-> MEM_COL <= 3'h4 && !MEM_WDATA[7];
    endproperty
    a_char_col: assert property (p_char_col) else $error("bad pattern column");
    property p_slverr;
        PSLVERR |-> PSEL && PENABLE;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error outside access");
endmodule // lcdhp_port_checker
bind lcdhp_port lcdhp_port_checker chk (.REF_CLK, .RST_B, .CS_N, .NIBBLE_BUS_OE, .BUSY_N_O,
    .BUSY_N_OE, .CMD_VALID, .CMD_BYTE, .MEM_RD, .MEM_WR, .MEM_COL, .MEM_WDATA, .PSEL,
    .PENABLE, .PSLVERR);

/* File: bench/lcdhp_host_model.sv */
// Host processor model on the nibble or serial link
`timescale 1ns/1ps
module lcdhp_host_model (
    // Clock and link type, high for serial
    input wire logic clk,
    input wire logic ser,
    // Device side
    input wire logic busy_n,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe,
    // Link pins
    output logic cs_n,
    output logic stb_n,
    output logic cd,
    output logic [3:0] pins
);
    logic [3:0] hv;
    // Wire level: each bit goes to whoever enables it
    assign pins = (dev_oe & dev_o) | (~dev_oe & hv);
    initial begin
        cs_n = 1'b0;
        stb_n = 1'b1;
        cd = 1'b0;
        hv = 4'h0;
    end
    task sel(input logic off);
        @(posedge clk);
        cs_n <= off;
    endtask
    // One byte, 8 cycles per strobe period; r holds what the bus showed
    task xfer(input logic c, input logic [7:0] b, output logic [7:0] r);
        @(posedge clk);
        cd <= c;
        for (int i = 0; i < (ser ? 8 : 2); i++) begin
            @(posedge clk);
            stb_n <= 1'b0;
            hv <= ser ? {3'h0, b[7-i]} : (i != 0) ? b[3:0] : b[7:4];
            repeat (4) @(posedge clk);
            stb_n <= 1'b1;
            repeat (3) @(posedge clk);
            if (ser) begin
                r[7-i] = pins[3];
            end else begin
                r[4*(1-i) +: 4] = pins;
            end
        end
        // Busy may start late, so give it time before polling
        repeat (6) @(posedge clk);
        while (busy_n !== 1'b1) @(posedge clk);
    endtask
endmodule // lcdhp_host_model

/* File: bench/test_lcd_host_port_and_char_writer.sv */
// Testbench for the LCD host port
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_lcd_host_port_and_char_writer;
    import lcdhp_pkg::*;
    logic REF_CLK, RST_B, IF_SELECT, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic CS_N, NIBBLE_STROBE_N, CMD_DATA_SEL, BUSY_N_O, BUSY_N_OE, CMD_VALID, MEM_RD, MEM_WR;
    logic [1:0] CHIP_ID_PINS;
    logic [3:0] NIBBLE_BUS_I, NIBBLE_BUS_O, NIBBLE_BUS_OE;
    logic [2:0] MEM_COL;
    logic [7:0] CMD_BYTE, MEM_WDATA, MEM_RDATA, r8;
    logic [APB_AW-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r32;
    logic [7:0] mem [0:7];
    logic err;
    int tests_run, mismatches, cycles, n_wr, n_rd, w0, k;
    lcdhp_port #(.GLYPH_ROM({GLYPH_N*GLYPH_W{1'b1}})) uut (.*);
    lcdhp_host_model host (.clk(REF_CLK), .busy_n(BUSY_N_OE ? BUSY_N_O : 1'b1),
        .dev_o(NIBBLE_BUS_O), .dev_oe(NIBBLE_BUS_OE), .cs_n(CS_N), .stb_n(NIBBLE_STROBE_N),
        .cd(CMD_DATA_SEL), .pins(NIBBLE_BUS_I), .ser(!IF_SELECT));
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // Display memory with a fixed pointer at address zero
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (MEM_WR) begin
            mem[MEM_COL] <= MEM_WDATA;
            n_wr <= n_wr + 1;
        end
        if (MEM_RD) begin
            MEM_RDATA <= mem[0];
            n_rd <= n_rd + 1;
        end
        if (cycles > 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1) @(posedge REF_CLK);
        r32 = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        RST_B = 1'b0;
        IF_SELECT = 1'b1;
        CHIP_ID_PINS = 2'h0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {tests_run, mismatches, cycles, n_wr, n_rd} = '0;
        for (k = 0; k < 8; k++) mem[k] = 8'hFF;
        repeat (4) @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(r32[ST_PAR_BIT], 1'b1)
        `CHK(r32[ST_MODE_LSB +: 3], 3'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, OFS_CTRL, 32'h0);
        host.xfer(1'b1, CMD_SET_WRITE, r8);
        `CHK(CMD_BYTE, CMD_SET_WRITE)
        host.xfer(1'b0, 8'hA5, r8);
        `CHK(mem[0], 8'hA5)
        host.xfer(1'b1, CMD_SET_AND, r8);
        host.xfer(1'b0, 8'h0F, r8);
        `CHK(mem[0], 8'h05)
        host.xfer(1'b1, CMD_SET_OR, r8);
        host.xfer(1'b0, 8'h30, r8);
        `CHK(mem[0], 8'h35)
        for (k = 0; k < 2; k++) begin
            w0 = n_wr;
            host.xfer(1'b1, k ? CMD_CHAR_RIGHT : CMD_CHAR_LEFT, r8);
            host.xfer(1'b0, k ? 8'hB1 : 8'h41, r8);
            `CHK(n_wr - w0, 5)
            `CHK(mem[4], 8'h7F)
        end
        mem[0] = 8'hC3;
        w0 = n_rd;
        host.xfer(1'b1, CMD_SET_READ, r8);
        `CHK(n_rd - w0, 1)
        host.xfer(1'b0, 8'h00, r8);
        `CHK(r8, 8'hC3)
        `CHK(n_rd - w0, 2)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(r32[ST_MODE_LSB +: 3], 3'h1)
        host.sel(1'b1);
        repeat (4) @(posedge REF_CLK);
        `CHK(BUSY_N_OE, 1'b0)
        `CHK(NIBBLE_BUS_OE, 4'h0)
        host.sel(1'b0);
        repeat (3) @(posedge REF_CLK);
        `CHK(BUSY_N_OE, 1'b1)
        apb(1'b1, OFS_CHIP_ADDR, 32'h1);
        @(posedge REF_CLK);
        `CHK(BUSY_N_OE, 1'b0)
        // Serial link needs a fresh reset with the strap low
        RST_B <= 1'b0;
        IF_SELECT <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(r32[ST_PAR_BIT], 1'b0)
        `CHK(r32[ST_MODE_LSB +: 3], 3'h0)
        host.xfer(1'b0, 8'h96, r8);
        `CHK(mem[0], 8'h96)
        mem[0] = 8'h5A;
        host.xfer(1'b1, CMD_SET_READ, r8);
        host.xfer(1'b0, 8'h00, r8);
        `CHK(r8, 8'h5A)
        end_of_test();
    end
endmodule // test_lcd_host_port_and_char_writer
